// ---- hdl/eewp_host.sv ----
// eewp_host: strobe-level host controller for a paged, write-protected eeprom
// Function
// (R1) Device blocks writes while supply sense shows low supply.
// (R2) Wait the power-on delay after supply good before any write.
// (R3) No write while output enable low, chip enable or write enable high.
// (R4) Write-enable or chip-enable low pulses under fifteen ns start nothing.
// (R5) Device ships with software protection off.
// (R6) Three code writes turn software protection on.
// (R7) While protected each write cycle is preceded by the three codes.
// (R8) Code writes keep the same byte timing as page loads.
// (R9) Protection survives power loss; only the disable sequence clears it.
// (R10) High-voltage address nine selects the 64-byte identification area.
// (R11) Programming ends within 10 ms, or 3.0 ms on fast parts.
// (R12) Next page byte starts within 150 us of previous strobe rising.
// (R13) Page address bits held constant on every falling write strobe.
// (R14) Protection switches at end of write period even with no data.
// (R15) After a code sequence one to 64 data bytes may follow.
// (R16) Toggle check with fixed address, no assumed start or end value.
// (R17) Load period closes without a new falling edge inside the window.
// (R18) Reading the last byte during programming gives inverted top bit.
// (R19) Toggle status bit alternates during programming, then stops.
// (R20) Chip and output enable low, write enable high, drives stored data.
// (R21) Supply good and high-voltage detect are digital control inputs.
module eewp_host
    import eewp_pkg::*;
#(
    parameter int PWRON_CYC_P     = eewp_pkg::PWRON_CYC,
    parameter int LOAD_WIN_CYC_P  = eewp_pkg::LOAD_WIN_CYC,
    parameter int WRITE_MAX_CYC_P = eewp_pkg::WRITE_MAX_CYC
) (
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rstn,
    // user command port
    input  wire logic                cmd_valid,
    output logic                     cmd_ready,
    input  wire eewp_pkg::eewp_cmd_t cmd,
    // user answer port
    output logic                     rsp_valid,
    output logic [7:0]               rsp_data,
    output logic                     rsp_timeout,
    output logic                     busy,
    output logic                     pwr_ok,
    // device side
    input  wire logic                vcc_ok,
    input  wire logic [7:0]          dq_in,
    output eewp_pkg::eewp_pins_t     pins
);
    import eewp_pkg::*;

    typedef enum {ST_IDLE, ST_SET, ST_WLOW, ST_WHIGH, ST_LOAD, ST_RD, ST_POLL, ST_PGAP} eewp_st_t;

    localparam logic [CNT_W-1:0] PWRON_END = CNT_W'(PWRON_CYC_P - 1);
    localparam logic [CNT_W-1:0] WP_END    = CNT_W'(WP_CYC - 1);
    localparam logic [CNT_W-1:0] WPH_END   = CNT_W'(WPH_CYC - 1);
    localparam logic [CNT_W-1:0] RD_END    = CNT_W'(ACC_CYC + SYNC_CYC);
    localparam logic [CNT_W-1:0] GAP_END   = CNT_W'(OEHP_CYC - 1);
    localparam logic [CNT_W-1:0] ACC_LIM   = CNT_W'(LOAD_WIN_CYC_P - LOAD_MARGIN_CYC);
    localparam logic [CNT_W-1:0] LOAD_END  = CNT_W'(LOAD_WIN_CYC_P + LOAD_MARGIN_CYC);
    localparam logic [CNT_W-1:0] WR_END    = CNT_W'(WRITE_MAX_CYC_P);

    eewp_st_t         state_reg;
    eewp_cmd_t        cmd_reg;
    logic [1:0]       step_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] wr_cnt_reg;
    logic [CNT_W-1:0] pwr_cnt_reg;
    logic [8:0]       page_reg;
    logic             prev_valid_reg;
    logic             prev_bit_reg;
    logic             vcc_m_reg;
    logic             vcc_s_reg;
    logic [7:0]       dq_m_reg;
    logic [7:0]       dq_s_reg;
    logic             pwr_ok_reg;
    logic             page_ok;
    logic             is_prot;

    function automatic logic [22:0] step_word(input logic [1:0] step, input eewp_cmd_t c);
        logic [14:0] a;
        a = c.id_area ? (ID_BASE | {9'h000, c.addr[5:0]}) : c.addr;
        case (step)
            2'h0:    step_word = {CODE_ADDR_A, CODE_DATA_A};
            2'h1:    step_word = {CODE_ADDR_B, CODE_DATA_B};
            2'h2:    step_word = {CODE_ADDR_A,
                                  (c.op == EEWP_OP_PROT_OFF) ? CODE_DATA_OFF : CODE_DATA_ON};
            default: step_word = {a, c.data};
        endcase
    endfunction : step_word

    // inputs from the pins are synchronised before use
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            vcc_m_reg <= 1'b0;
            vcc_s_reg <= 1'b0;
            dq_m_reg  <= 8'h00;
            dq_s_reg  <= 8'h00;
        end else begin
            vcc_m_reg <= vcc_ok; // R21
            vcc_s_reg <= vcc_m_reg;
            dq_m_reg  <= dq_in;
            dq_s_reg  <= dq_m_reg;
        end
    end

    // supply qualification: a dip restarts the whole delay
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pwr_cnt_reg <= '0;
            pwr_ok_reg  <= 1'b0;
        end else if (!vcc_s_reg) begin
            pwr_cnt_reg <= '0; // R1
            pwr_ok_reg  <= 1'b0; // R1
        end else if (pwr_cnt_reg == PWRON_END) begin
            pwr_ok_reg  <= 1'b1; // R2
        end else begin
            pwr_cnt_reg <= pwr_cnt_reg + 1'b1; // R2
        end
    end

    assign pwr_ok  = pwr_ok_reg;
    assign busy    = (state_reg != ST_IDLE);
    assign is_prot = (cmd_reg.op == EEWP_OP_PROT_ON) || (cmd_reg.op == EEWP_OP_PROT_OFF);
    // only plain writes to the open page may extend a load
    assign page_ok = (cmd.op == EEWP_OP_WRITE) && !cmd.sdp && (cmd.id_area == cmd_reg.id_area)
                   && (cmd.addr[14:6] == page_reg); // R13
    assign cmd_ready = pwr_ok_reg && ((state_reg == ST_IDLE) ||
                       ((state_reg == ST_LOAD) && !cmd_reg.last && !is_prot && page_ok
                        && (cnt_reg < ACC_LIM))); // R12

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg      <= ST_IDLE;
            cmd_reg        <= '0;
            step_reg       <= 2'h0;
            cnt_reg        <= '0;
            wr_cnt_reg     <= '0;
            page_reg       <= 9'h000;
            prev_valid_reg <= 1'b0;
            prev_bit_reg   <= 1'b0;
            rsp_valid      <= 1'b0;
            rsp_data       <= 8'h00;
            rsp_timeout    <= 1'b0;
            pins           <= '{addr: 15'h0000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                                hv_en: 1'b0, dq_out: 8'h00, dq_oe_n: 1'b1};
        end else begin
            rsp_valid   <= 1'b0;
            rsp_timeout <= 1'b0;
            cnt_reg     <= cnt_reg + 1'b1;
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        cmd_reg     <= cmd;
                        cnt_reg     <= '0;
                        pins.hv_en  <= cmd.id_area; // R10
                        pins.ce_n   <= 1'b0;
                        if (cmd.op == EEWP_OP_READ) begin
                            {pins.addr, pins.dq_out} <= step_word(DATA_STEP, cmd); // R20
                            pins.oe_n <= 1'b0; // R20
                            state_reg <= ST_RD;
                        end else begin
                            step_reg  <= (cmd.op == EEWP_OP_WRITE && !cmd.sdp) ? DATA_STEP : 2'h0; // R7
                            {pins.addr, pins.dq_out} <= step_word(
                                (cmd.op == EEWP_OP_WRITE && !cmd.sdp) ? DATA_STEP : 2'h0, cmd); // R6
                            pins.dq_oe_n <= 1'b0;
                            pins.oe_n    <= 1'b1; // R3
                            state_reg    <= ST_SET;
                        end
                    end
                end
                ST_SET: begin
                    pins.we_n <= 1'b0;
                    cnt_reg   <= '0;
                    state_reg <= ST_WLOW;
                end
                ST_WLOW: begin
                    if (cnt_reg == WP_END) begin
                        pins.we_n <= 1'b1; // R4
                        cnt_reg   <= '0;
                        state_reg <= ST_WHIGH;
                    end
                end
                ST_WHIGH: begin
                    if (cnt_reg == WPH_END) begin
                        cnt_reg <= '0;
                        if (step_reg < 2'h2 || (step_reg == 2'h2 && !is_prot)) begin
                            step_reg  <= step_reg + 1'b1; // R8
                            {pins.addr, pins.dq_out} <= step_word(step_reg + 1'b1, cmd_reg);
                            state_reg <= ST_SET;
                        end else begin
                            page_reg     <= pins.addr[14:6];
                            pins.dq_oe_n <= 1'b1;
                            state_reg    <= ST_LOAD; // R14
                        end
                    end
                end
                ST_LOAD: begin
                    if (cmd_valid && cmd_ready) begin
                        cmd_reg      <= cmd;
                        step_reg     <= DATA_STEP;
                        {pins.addr, pins.dq_out} <= step_word(DATA_STEP, cmd); // R13
                        pins.dq_oe_n <= 1'b0;
                        cnt_reg      <= '0;
                        state_reg    <= ST_SET;
                    end else if (cnt_reg == LOAD_END) begin
                        // the device has closed the load by now, so toggling is meaningful
                        cnt_reg        <= '0; // R17
                        wr_cnt_reg     <= '0;
                        prev_valid_reg <= 1'b0; // R16
                        pins.oe_n      <= 1'b0;
                        state_reg      <= ST_POLL;
                    end
                end
                ST_RD: begin
                    if (cnt_reg == RD_END) begin
                        rsp_valid   <= 1'b1;
                        rsp_data    <= dq_s_reg; // R20
                        pins.ce_n   <= 1'b1;
                        pins.oe_n   <= 1'b1;
                        pins.hv_en  <= 1'b0;
                        state_reg   <= ST_IDLE;
                    end
                end
                ST_POLL: begin
                    if (cnt_reg == RD_END) begin
                        cnt_reg   <= '0;
                        pins.oe_n <= 1'b1;
                        if (prev_valid_reg && dq_s_reg[6] == prev_bit_reg) begin
                            rsp_valid  <= 1'b1; // R19
                            rsp_data   <= dq_s_reg;
                            pins.ce_n  <= 1'b1;
                            pins.hv_en <= 1'b0;
                            state_reg  <= ST_IDLE;
                        end else begin
                            prev_valid_reg <= 1'b1;
                            prev_bit_reg   <= dq_s_reg[6]; // R16
                            state_reg      <= ST_PGAP;
                        end
                    end
                end
                ST_PGAP: begin
                    if (cnt_reg == GAP_END) begin
                        cnt_reg   <= '0;
                        pins.oe_n <= 1'b0;
                        state_reg <= ST_POLL;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
            // programming that overruns the longest write time is reported and abandoned
            if (state_reg == ST_POLL || state_reg == ST_PGAP) begin
                wr_cnt_reg <= wr_cnt_reg + 1'b1;
                if (wr_cnt_reg >= WR_END) begin
                    rsp_timeout <= 1'b1; // R11
                    rsp_valid   <= 1'b1;
                    pins.ce_n   <= 1'b1;
                    pins.oe_n   <= 1'b1;
                    pins.hv_en  <= 1'b0;
                    state_reg   <= ST_IDLE;
                end
            end
        end
    end

    property p_oe_high_in_write;
        @(posedge sys_clk) disable iff (!rstn) !pins.we_n |-> (pins.oe_n && !pins.ce_n);
    endproperty
    a_oe_high_in_write: assert property (p_oe_high_in_write) else $error("strobe overlap"); // R3

    property p_we_pulse_width;
        @(posedge sys_clk) disable iff (!rstn) $fell(pins.we_n) |-> (!pins.we_n)[*8];
    endproperty
    a_we_pulse_width: assert property (p_we_pulse_width) else $error("write pulse short"); // R4

    property p_no_write_unpowered;
        @(posedge sys_clk) disable iff (!rstn) $fell(pins.we_n) |-> $past(pwr_ok_reg, 2);
    endproperty
    a_no_write_unpowered: assert property (p_no_write_unpowered) else $error("write unpowered"); // R2

    property p_supply_drop;
        @(posedge sys_clk) disable iff (!rstn) !vcc_s_reg |=> !pwr_ok_reg;
    endproperty
    a_supply_drop: assert property (p_supply_drop) else $error("supply drop missed"); // R1

    property p_data_driven;
        @(posedge sys_clk) disable iff (!rstn) !pins.we_n |-> !pins.dq_oe_n;
    endproperty
    a_data_driven: assert property (p_data_driven) else $error("data not driven"); // R8

    property p_no_drive_on_read;
        @(posedge sys_clk) disable iff (!rstn) !pins.oe_n |-> pins.dq_oe_n;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("bus contention"); // R20

    property p_page_held;
        @(posedge sys_clk) disable iff (!rstn)
            (state_reg == ST_LOAD && cmd_valid && cmd_ready) |=> ##1 $fell(pins.we_n)
            ##0 (pins.addr[14:6] == $past(page_reg, 2));
    endproperty
    a_page_held: assert property (p_page_held) else $error("page changed"); // R13

    property p_load_window;
        @(posedge sys_clk) disable iff (!rstn)
            (state_reg == ST_LOAD && cmd_valid && cmd_ready)
            |-> (cnt_reg + WPH_CYC + 3 < LOAD_WIN_CYC_P);
    endproperty
    a_load_window: assert property (p_load_window) else $error("late byte"); // R12

    property p_code_first;
        @(posedge sys_clk) disable iff (!rstn)
            (state_reg == ST_IDLE && cmd_valid && cmd_ready && cmd.sdp
             && cmd.op != EEWP_OP_READ) |=> ##1
            (pins.addr == CODE_ADDR_A && pins.dq_out == CODE_DATA_A && !pins.we_n);
    endproperty
    a_code_first: assert property (p_code_first) else $error("code write missing"); // R7

    property p_poll_done;
        @(posedge sys_clk) disable iff (!rstn)
            (state_reg == ST_POLL && cnt_reg == RD_END && prev_valid_reg
             && dq_s_reg[6] == prev_bit_reg) |=> (rsp_valid && state_reg == ST_IDLE);
    endproperty
    a_poll_done: assert property (p_poll_done) else $error("toggle end missed"); // R19
endmodule : eewp_host

// ---- hdl/eewp_pkg.sv ----
// eewp_pkg: constants and carrier types for the paged eeprom host controller
package eewp_pkg;
    localparam int CLK_NS          = 10;
    localparam int WP_NS           = 100;
    localparam int WP_CYC          = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_NS          = 50;
    localparam int WPH_CYC         = (WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_NS          = 350;
    localparam int ACC_CYC         = (ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int OEHP_NS         = 150;
    localparam int OEHP_CYC        = (OEHP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_CYC        = 2;
    localparam int PWRON_MS        = 5;
    localparam int PWRON_CYC       = PWRON_MS * 1000000 / CLK_NS;
    localparam int LOAD_WIN_US     = 150;
    localparam int LOAD_WIN_CYC    = LOAD_WIN_US * 1000 / CLK_NS;
    localparam int LOAD_MARGIN_CYC = 100;
    localparam int WRITE_MAX_MS    = 10;
    localparam int WRITE_MAX_CYC   = WRITE_MAX_MS * 1000000 / CLK_NS;
    localparam int WRITE_FAST_US   = 3000;
    localparam int WRITE_FAST_CYC  = WRITE_FAST_US * 1000 / CLK_NS;
    localparam int CNT_W           = 20;
    localparam logic [14:0] ID_BASE      = 15'h7fc0;
    localparam logic [14:0] CODE_ADDR_A  = 15'h5555;
    localparam logic [14:0] CODE_ADDR_B  = 15'h2aaa;
    localparam logic [7:0]  CODE_DATA_A  = 8'haa;
    localparam logic [7:0]  CODE_DATA_B  = 8'h55;
    localparam logic [7:0]  CODE_DATA_ON = 8'ha0;
    localparam logic [7:0]  CODE_DATA_OFF = 8'h80;
    localparam logic [1:0]  DATA_STEP    = 2'h3;

    typedef enum logic [1:0] {
        EEWP_OP_READ,
        EEWP_OP_WRITE,
        EEWP_OP_PROT_ON,
        EEWP_OP_PROT_OFF
    } eewp_op_t;

    typedef struct packed {
        eewp_op_t    op;
        logic        sdp;
        logic        id_area;
        logic        last;
        logic [14:0] addr;
        logic [7:0]  data;
    } eewp_cmd_t;

    typedef struct packed {
        logic [14:0] addr;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        hv_en;
        logic [7:0]  dq_out;
        logic        dq_oe_n;
    } eewp_pins_t;
endpackage : eewp_pkg

// ---- testbench/eewp_dev_model.sv ----
// eewp_dev_model: behavioural paged eeprom with software protection, seen from its pins
module eewp_dev_model
    import eewp_pkg::*;
#(
    parameter int PWR_CYC  = 50,
    parameter int LOAD_CYC = 300
) (
    // timer clock
    input  wire logic                 sys_clk,
    // device pins
    input  wire logic                 vcc_ok,
    input  wire eewp_pkg::eewp_pins_t pins,
    output logic [7:0]                dq,
    // programming time in cycles, set by the bench
    input  wire logic [31:0]          prog_cyc
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0]  mem [0:32767];
    logic [7:0]  id_mem [0:63];
    logic [7:0]  pg [0:63];
    logic [63:0] hit    = '0;
    logic [14:0] pa, la;
    logic [7:0]  last_d = '0;
    logic [7:0]  bus_q  = '0;
    logic [7:0]  rd_val;
    logic        prot   = 1'b0;
    logic        pg_id  = 1'b0;
    logic        on_p   = 1'b0;
    logic        off_p  = 1'b0;
    logic        tog    = 1'b0;
    logic        we_q   = 1'b1;
    logic        oe_q   = 1'b1;
    logic        ce_q   = 1'b1;
    logic        rd_on, wr_ok;
    int          pwr    = 0;
    int          low    = 0;
    int          win    = LOAD_CYC + 1;
    int          left   = 0;
    int          step   = 0;

    initial begin
        for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
        for (int i = 0; i < 64; i++) id_mem[i] = 8'hff;
    end

    assign wr_ok  = vcc_ok && pwr >= PWR_CYC && left == 0;
    assign rd_on  = !pins.ce_n && !pins.oe_n && pins.we_n;
    assign rd_val = left != 0 ? {~last_d[7], tog, last_d[5:0]} :
                    (pins.hv_en && pins.addr >= ID_BASE) ? id_mem[pins.addr[5:0]] :
                    mem[pins.addr];
    // a released bus shows the inverse of its last value, so a stale byte never matches
    assign dq = !pins.dq_oe_n ? pins.dq_out : rd_on ? rd_val : ~bus_q;

    always @(posedge sys_clk) begin
        pwr <= vcc_ok ? pwr + 1 : 0;
        we_q <= pins.we_n;
        oe_q <= pins.oe_n;
        ce_q <= pins.ce_n;
        if (!pins.dq_oe_n || rd_on) bus_q <= dq;
        if (!pins.we_n && we_q) la <= pins.addr;
        low <= (!pins.we_n && !pins.ce_n && pins.oe_n) ? low + 1 : 0;
        if (win <= LOAD_CYC) win <= win + 1;
        if (left != 0 && rd_on && (oe_q || ce_q)) tog <= ~tog;
        if (pins.we_n && !we_q && low >= 2 && wr_ok) begin
            win <= 0;
            if (step == 0 && la == CODE_ADDR_A && pins.dq_out == CODE_DATA_A) step <= 1;
            else if (step == 1 && la == CODE_ADDR_B && pins.dq_out == CODE_DATA_B) step <= 2;
            else if (step == 2 && la == CODE_ADDR_A
                     && pins.dq_out inside {CODE_DATA_ON, CODE_DATA_OFF}) begin
                step <= 3;
                on_p <= pins.dq_out == CODE_DATA_ON;
                off_p <= pins.dq_out == CODE_DATA_OFF;
            end else if (!prot || step == 3) begin
                pg[la[5:0]] <= pins.dq_out;
                hit[la[5:0]] <= 1'b1;
                pa <= la;
                pg_id <= pins.hv_en;
                last_d <= pins.dq_out;
            end
        end
        if (win == LOAD_CYC) begin
            if (hit != 0 || on_p || off_p) left <= prog_cyc;
            else step <= 0;
        end
        if (left > 1) left <= left - 1;
        if (left == 1) begin
            left <= 0;
            for (int i = 0; i < 64; i++)
                if (hit[i] && pg_id) id_mem[i] <= pg[i];
                else if (hit[i]) mem[{pa[14:6], i[5:0]}] <= pg[i];
            prot <= (prot || on_p) && !off_p;
            hit <= '0;
            on_p <= 1'b0;
            off_p <= 1'b0;
            step <= 0;
        end
    end
endmodule : eewp_dev_model

// ---- testbench/eewp_host_test.sv ----
// eewp_host_test: self-checking bench for the eeprom host controller
module eewp_host_test;
    timeunit 1ns;
    timeprecision 100ps;
    import eewp_pkg::*;
    localparam int PWR  = 50;
    localparam int LWIN = 300;
    localparam int WMAX = 2000;
    logic       sys_clk    = 1'b0;
    logic       rstn       = 1'b0;
    logic       cmd_valid  = 1'b0;
    logic       vcc_ok     = 1'b0;
    eewp_cmd_t  cmd        = '0;
    logic       cmd_ready, rsp_valid, rsp_timeout, busy, pwr_ok, got_to;
    logic [7:0] rsp_data, dq_in, got;
    eewp_pins_t pins;
    int         prog_cyc   = 400;
    int         mismatches = 0;
    int         n_checks   = 0;
    int         wl         = 0;

    eewp_host #(.PWRON_CYC_P(PWR), .LOAD_WIN_CYC_P(LWIN), .WRITE_MAX_CYC_P(WMAX)) i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_timeout(rsp_timeout),
        .busy(busy), .pwr_ok(pwr_ok), .vcc_ok(vcc_ok), .dq_in(dq_in), .pins(pins));
    eewp_dev_model #(.PWR_CYC(PWR), .LOAD_CYC(LWIN)) i_dev (
        .sys_clk(sys_clk), .vcc_ok(vcc_ok), .pins(pins), .dq(dq_in), .prog_cyc(prog_cyc));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [14:0] seen, input logic [14:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic issue(input eewp_op_t o, input logic sdp, id, lst,
                         input logic [14:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge sys_clk);
        cmd_valid = 1'b1;
        cmd = '{o, sdp, id, lst, a, d};
        #1;
        while (cmd_ready !== 1'b1 && n < 20000) begin
            @(negedge sys_clk);
            #1;
            n++;
        end
        check(n == 20000, 0, "request never taken");
        @(negedge sys_clk);
        cmd_valid = 1'b0;
    endtask : issue

    task automatic wait_rsp;
        int n;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 20000) begin
            @(negedge sys_clk);
            n++;
        end
        check(n == 20000, 0, "no answer");
        got = rsp_data;
        got_to = rsp_timeout;
    endtask : wait_rsp

    task automatic xfer(input eewp_op_t o, input logic sdp, id,
                        input logic [14:0] a, input logic [7:0] d);
        issue(o, sdp, id, 1'b1, a, d);
        wait_rsp;
    endtask : xfer

    task automatic rd_chk(input logic id, input logic [14:0] a, input logic [7:0] exp);
        xfer(EEWP_OP_READ, 1'b0, id, a, 8'h00);
        check(got, exp, "read data");
    endtask : rd_chk

    // every write strobe must be qualified and at least WP_CYC cycles wide
    always @(negedge sys_clk) begin
        if (pins.we_n === 1'b0) begin
            wl++;
            check(pins.ce_n | !pins.oe_n | pins.dq_oe_n, 0, "strobe qualifiers");
        end else if (wl != 0) begin
            check(wl >= WP_CYC, 1, "write pulse too short");
            wl = 0;
        end
    end

    task automatic t_power;
        repeat (20) @(negedge sys_clk);
        check(cmd_ready, 0, "ready without supply");
        vcc_ok = 1'b1;
        repeat (PWR - 2) @(negedge sys_clk);
        check(pwr_ok, 0, "early power good");
        repeat (8) @(negedge sys_clk);
        check(pwr_ok, 1, "power good");
        $display("test power done");
    endtask : t_power

    task automatic t_rw;
        time t0;
        issue(EEWP_OP_WRITE, 1'b0, 1'b0, 1'b1, 15'h0123, 8'h5a);
        t0 = $time;
        check(busy, 1, "busy during write");
        wait_rsp;
        check(($time - t0) / 10 > LWIN, 1, "answer inside load window");
        check(got, 8'h5a, "final poll byte");
        check(got_to, 0, "false timeout");
        rd_chk(1'b0, 15'h0123, 8'h5a);
        $display("test write read done");
    endtask : t_rw

    task automatic t_page;
        issue(EEWP_OP_WRITE, 1'b0, 1'b0, 1'b0, 15'h0240, 8'h01);
        issue(EEWP_OP_WRITE, 1'b0, 1'b0, 1'b0, 15'h0241, 8'h02);
        issue(EEWP_OP_WRITE, 1'b0, 1'b0, 1'b1, 15'h027f, 8'h03);
        wait_rsp;
        check(got, 8'h03, "page poll byte");
        rd_chk(1'b0, 15'h0240, 8'h01);
        rd_chk(1'b0, 15'h0241, 8'h02);
        rd_chk(1'b0, 15'h027f, 8'h03);
        rd_chk(1'b0, 15'h0242, 8'hff);
        $display("test page done");
    endtask : t_page

    task automatic t_prot;
        xfer(EEWP_OP_PROT_ON, 1'b0, 1'b0, 15'h0000, 8'h00);
        @(negedge sys_clk);
        vcc_ok = 1'b0;
        repeat (10) @(negedge sys_clk);
        vcc_ok = 1'b1;
        xfer(EEWP_OP_WRITE, 1'b0, 1'b0, 15'h0300, 8'h11);
        rd_chk(1'b0, 15'h0300, 8'hff);
        xfer(EEWP_OP_WRITE, 1'b1, 1'b0, 15'h0300, 8'h22);
        rd_chk(1'b0, 15'h0300, 8'h22);
        xfer(EEWP_OP_PROT_OFF, 1'b0, 1'b0, 15'h0000, 8'h00);
        xfer(EEWP_OP_WRITE, 1'b0, 1'b0, 15'h0301, 8'h33);
        rd_chk(1'b0, 15'h0301, 8'h33);
        $display("test protection done");
    endtask : t_prot

    task automatic t_id;
        xfer(EEWP_OP_WRITE, 1'b0, 1'b1, 15'h7fc5, 8'hc3);
        issue(EEWP_OP_READ, 1'b0, 1'b1, 1'b1, 15'h7fc5, 8'h00);
        @(negedge sys_clk);
        check(pins.hv_en, 1, "high voltage on id read");
        check(pins.addr, 15'h7fc5, "id address");
        wait_rsp;
        check(got, 8'hc3, "id data");
        rd_chk(1'b0, 15'h7fc5, 8'hff);
        $display("test id area done");
    endtask : t_id

    task automatic t_timeout;
        prog_cyc = 3000;
        xfer(EEWP_OP_WRITE, 1'b0, 1'b0, 15'h0400, 8'h77);
        check(got_to, 1, "slow part not reported");
        prog_cyc = 400;
        repeat (3000) @(negedge sys_clk);
        rd_chk(1'b0, 15'h0400, 8'h77);
        $display("test timeout done");
    endtask : t_timeout

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    initial begin
        #600000;
        mismatches++;
        finish_test;
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        rstn = 1'b1;
        t_power;
        t_rw;
        t_page;
        t_prot;
        t_id;
        t_timeout;
        finish_test;
    end
endmodule : eewp_host_test
